// ==== design/dma_cfg_pkg.sv ====
// Purpose: Constants for the DMA FIFO burst configuration block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   FIFO sizes in bytes; counts are kept in bytes throughout
package dma_cfg_pkg;
  localparam logic [3:0]  ADDR_CONFIG     = 4'h0;   // Data configuration register
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;   // Live FIFO levels and requests
  localparam logic [15:0] CONFIG_RESET    = 16'h0000;
  localparam int          WAIT_LSB        = 6;
  localparam int          WIDTH_BIT       = 5;
  localparam int          BURST_BIT       = 4;
  localparam int          RXT_LSB         = 2;
  localparam int          TXT_LSB         = 0;
  localparam logic [5:0]  FIFO_BYTES      = 6'h20;  // 32-byte FIFOs
  localparam logic [5:0]  BYTES_16        = 6'h02;
  localparam logic [5:0]  BYTES_32        = 6'h04;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_T1   = 4'h2,
    ST_T2   = 4'h4,
    ST_WAIT = 4'h8
  } bus_state_e;

  // Receive trigger code to bytes
  function automatic logic [5:0] rx_bytes(input logic [1:0] code);
    case (code)
      2'h0:    rx_bytes = 6'h04;
      2'h1:    rx_bytes = 6'h08;
      2'h2:    rx_bytes = 6'h10;
      default: rx_bytes = 6'h18;
    endcase
  endfunction : rx_bytes

  // Transmit trigger code to bytes
  function automatic logic [5:0] tx_bytes(input logic [1:0] code);
    case (code)
      2'h0:    tx_bytes = 6'h08;
      2'h1:    tx_bytes = 6'h10;
      2'h2:    tx_bytes = 6'h18;
      default: tx_bytes = 6'h1C;
    endcase
  endfunction : tx_bytes
endpackage : dma_cfg_pkg

// ==== design/dma_fifo_burst_config.sv ====
// Purpose: DMA engine control set by the data configuration register
// Assumes: FIFO levels are reported in bytes; memory completes each cycle
//          FIFO side updates its level the cycle after dma_item_done
// Notes:   One DMA cycle moves one data-path item; T1 then T2 plus waits
//          Config writes are meant to land while the engine is idle
//          No new request in the cycle a transfer ends: the level is stale
// Summary of operation
// RL1: Each DMA cycle gets extra T2 states equal to the wait-state field.
// RL2: Width bit 0 moves 16-bit items, bit 1 moves 32-bit items.
// RL3: Empty/fill mode runs until rx FIFO empty or tx FIFO full.
// RL4: Block mode ends a transfer once the threshold amount has moved.
// RL5: Receive request raised when rx FIFO holds 4, 8, 16 or 24 bytes.
// RL6: Block mode writes exactly the rx threshold amount per receive block.
// RL7: Transmit FIFO minimum level is 8, 16, 24 or 28 bytes by code.
// RL8: Block mode reads the tx threshold amount in one transmit burst.
// RL9: If less is needed to fill tx FIFO, only those reads are issued.
// RL10: Transmit bus request when tx FIFO level drops below threshold.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dma_fifo_burst_config
  import dma_cfg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [5:0]  rx_fifo_level,
  input  wire logic [5:0]  tx_fifo_level,
  output logic             bus_request,
  input  wire logic        bus_grant,
  output logic             dma_strobe,
  output logic             dma_write,
  output logic             dma_wide,
  output logic             dma_item_done
);

  logic [15:0] data_config_reg;
  bus_state_e  state;
  bus_state_e  next_state;
  logic [1:0]  wait_cnt;
  logic [5:0]  moved;
  logic        dir_rx;
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // Configuration fields
  wire [1:0] dma_wait_states        = data_config_reg[WAIT_LSB+1:WAIT_LSB];
  wire       dma_path_width         = data_config_reg[WIDTH_BIT];
  wire       burst_style_select     = data_config_reg[BURST_BIT];
  wire [1:0] rx_queue_trigger_level = data_config_reg[RXT_LSB+1:RXT_LSB];
  wire [1:0] tx_queue_trigger_level = data_config_reg[TXT_LSB+1:TXT_LSB];
  wire [5:0] item_bytes  = dma_path_width ? BYTES_32 : BYTES_16;  // RL2
  wire [5:0] rx_thresh   = rx_bytes(rx_queue_trigger_level);
  wire [5:0] tx_thresh   = tx_bytes(tx_queue_trigger_level);

  // Request conditions
  wire rx_req = rx_fifo_level >= rx_thresh;  // RL5
  wire tx_req = tx_fifo_level < tx_thresh;   // RL10 RL7

  // A finished transfer leaves the level stale for one cycle; skip it
  wire start_ok = (rx_req || tx_req) && !dma_item_done;  // RL5 RL10

  // Room left in the transmit FIFO and bytes moved after this item
  wire [5:0] tx_room  = FIFO_BYTES - tx_fifo_level;
  wire [5:0] moved_nx = moved + item_bytes;

  // End of transfer after the item now finishing
  wire rx_stop = burst_style_select ? (moved_nx >= rx_thresh)       // RL4 RL6
                                    : (rx_fifo_level <= item_bytes); // RL3
  wire tx_stop = (burst_style_select && moved_nx >= tx_thresh)       // RL4 RL8
               || (tx_room <= item_bytes);                           // RL3 RL9
  wire xfer_end  = dir_rx ? rx_stop : tx_stop;

  // Last bus state of an item: T2 with no waits, or the final wait state
  wire t2_last   = (state == ST_T2) && (dma_wait_states == 2'h0);        // RL1
  wire wait_last = (state == ST_WAIT) && (wait_cnt == dma_wait_states);  // RL1
  wire item_last = t2_last || wait_last;

  // Wait counter: one on entry to the wait states, then counts up
  wire [1:0] next_wait_cnt = (state == ST_T2)   ? 2'h1
                           : (state == ST_WAIT) ? wait_cnt + 2'h1
                           : 2'h0;

  // DMA cycle sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (bus_grant && start_ok) next_state = ST_T1;
      ST_T1:   next_state = ST_T2;
      ST_T2:   next_state = (dma_wait_states == 2'h0) ? (xfer_end ? ST_IDLE : ST_T1) : ST_WAIT;
      ST_WAIT: if (wait_last) next_state = xfer_end ? ST_IDLE : ST_T1;  // RL1
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      wait_cnt      <= 2'h0;
      moved         <= 6'h00;
      dir_rx        <= 1'b0;
      bus_request   <= 1'b0;
      dma_strobe    <= 1'b0;
      dma_write     <= 1'b0;
      dma_wide      <= 1'b0;
      dma_item_done <= 1'b0;
    end else begin
      state         <= next_state;
      // Request held from the idle decision until the last state ends
      bus_request   <= (state == ST_IDLE) ? start_ok
                                          : (next_state != ST_IDLE);
      dma_strobe    <= (next_state != ST_IDLE);
      dma_item_done <= item_last;
      dma_wide      <= dma_path_width;  // RL2
      dma_write     <= (state == ST_IDLE) ? rx_req : dir_rx;
      if (state == ST_IDLE) begin
        dir_rx <= rx_req;
        moved  <= 6'h00;
      end else if (item_last) begin
        moved <= moved_nx;
      end
      wait_cnt <= next_wait_cnt;  // RL1
    end
  end

  // AXI write channel capture
  wire aw_ok   = aw_held || s_axi_awvalid;
  wire w_ok    = w_held || s_axi_wvalid;
  wire do_wr   = aw_ok && w_ok && !s_axi_bvalid;
  wire [3:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb  = w_held ? w_strb : s_axi_wstrb;
  wire wr_hit  = wr_addr == ADDR_CONFIG;
  wire rd_hit  = (s_axi_araddr == ADDR_CONFIG) || (s_axi_araddr == ADDR_STATUS);
  wire [31:0] rd_val = (s_axi_araddr == ADDR_CONFIG) ? {16'h0000, data_config_reg}
                     : {16'h0000, bus_request, dir_rx, 2'h0, tx_fifo_level, rx_fifo_level};

  // Register write and response
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_config_reg <= CONFIG_RESET;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      // Ready pulses for one cycle, then waits until the held pair drains and the write response is taken
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status is read only; a write to it is ignored but accepted
        s_axi_bresp  <= (aw_addr == ADDR_STATUS || wr_hit) ? RESP_OKAY
                                                           : RESP_SLVERR;
        if (wr_hit && wr_strb[0]) data_config_reg[7:0]  <= wr_data[7:0];
        if (wr_hit && wr_strb[1]) data_config_reg[15:8] <= wr_data[15:8];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      // One read at a time; data stands until the master takes it
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? rd_val : 32'h0000_0000;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Write-ready summary kept for debug visibility only
  wire unused_ok = do_wr;

endmodule : dma_fifo_burst_config
`default_nettype wire

// ==== verification/dma_fifo_burst_config_asserts.sv ====
// Purpose: Port checker
// Assumes: Config written while idle
// Notes:   Config mirrored at W
`timescale 1ns/10ps
`default_nettype none
module dma_fifo_burst_config_asserts
  import dma_cfg_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [5:0]  rx_fifo_level,
  input wire logic [5:0]  tx_fifo_level,
  input wire logic        bus_request,
  input wire logic        dma_strobe,
  input wire logic        dma_write,
  input wire logic        dma_wide,
  input wire logic        dma_item_done
);
  logic [15:0] cfg;
  logic [5:0]  bytes;
  logic [5:0]  rxt;
  logic [5:0]  txt;
  logic [2:0]  cnt;
  logic [5:0]  sz;
  // Bytes in one data-path item
  assign sz = dma_wide ? 6'h04 : 6'h02;
  // Thresholds in bytes
  assign rxt = (cfg[3:2] == 2'h3) ? 6'h18 : 6'h04 << cfg[3:2];
  assign txt = (cfg[1:0] == 2'h3) ? 6'h1C : 6'h08 * ({4'h0, cfg[1:0]} + 6'h01);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Config mirror, bytes per transfer, strobe cycles per item
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg   <= 16'h0000;
      bytes <= 6'h00;
      cnt   <= 3'h0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) cfg <= s_axi_wdata[15:0];
      bytes <= !bus_request ? 6'h00 : bytes + (dma_item_done ? sz : 6'h00);
      cnt   <= dma_item_done ? {2'h0, dma_strobe} : cnt + {2'h0, dma_strobe};
    end
  end
  property p_wait_states;
    dma_item_done |-> cnt == {1'b0, cfg[7:6]} + 3'h2;
  endproperty
  a_wait_states: assert property (p_wait_states) else $error("bad states per item");
  property p_path_width;
    dma_strobe |-> dma_wide == cfg[WIDTH_BIT];
  endproperty
  a_path_width: assert property (p_path_width) else $error("bad path width");
  property p_fill_end;
    $fell(bus_request) && !cfg[BURST_BIT] |->
      ($past(dma_write) ? rx_fifo_level <= sz : tx_fifo_level + sz >= 6'h20);
  endproperty
  a_fill_end: assert property (p_fill_end) else $error("fill transfer ended early");
  property p_block_rx;
    $fell(bus_request) && cfg[BURST_BIT] && $past(dma_write) |-> bytes + sz == rxt;
  endproperty
  a_block_rx: assert property (p_block_rx) else $error("bad rx block size");
  property p_block_tx;
    $fell(bus_request) && cfg[BURST_BIT] && !$past(dma_write) |-> bytes + sz <= txt;
  endproperty
  a_block_tx: assert property (p_block_tx) else $error("tx burst too long");
  property p_rx_request;
    !bus_request && !dma_item_done && rx_fifo_level >= rxt |=> bus_request;
  endproperty
  a_rx_request: assert property (p_rx_request) else $error("no rx request");
  property p_tx_request;
    !bus_request && !dma_item_done && tx_fifo_level < txt |=> bus_request;
  endproperty
  a_tx_request: assert property (p_tx_request) else $error("no tx request");
  property p_strobe_req;
    dma_strobe |-> bus_request;
  endproperty
  a_strobe_req: assert property (p_strobe_req) else $error("strobe without request");
endmodule : dma_fifo_burst_config_asserts
bind dma_fifo_burst_config dma_fifo_burst_config_asserts u_asserts (.*);
`default_nettype wire

// ==== verification/mem_bus_model.sv ====
// Purpose: System memory bus arbiter
// Assumes: Grant held while requested
// Notes:   slow delays the grant
`timescale 1ns/10ps
`default_nettype none
module mem_bus_model (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic bus_request,
  input  wire logic slow,
  output logic      bus_grant
);
  logic [2:0] age;
  // Grant next cycle, or eight cycles after the request when slow
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      age       <= 3'h0;
      bus_grant <= 1'b0;
    end else begin
      age       <= bus_request ? age + 3'h1 : 3'h0;
      bus_grant <= bus_request && (!slow || bus_grant || age == 3'h7);
    end
  end
endmodule : mem_bus_model
`default_nettype wire

// ==== verification/tb_dma_fifo_burst_config.sv ====
// Purpose: Self-checking bench
// Assumes: FIFO levels follow moved items
// Notes:   Random waits and widths
`timescale 1ns/10ps
`default_nettype none
module tb_dma_fifo_burst_config;
  import dma_cfg_pkg::*;
  logic core_clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, slow = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_request, bus_grant;
  logic dma_strobe, dma_write, dma_wide, dma_item_done;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, w;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [5:0] rx_fifo_level = 0, tx_fifo_level = 6'h20, sz;
  logic [15:0] cfg;
  int n_errors = 0, n_checks = 0, cyc = 0, moved = 0, lim, t;
  int rxb[4] = '{4, 8, 16, 24};
  int txb[4] = '{8, 16, 24, 28};
  dma_fifo_burst_config DUT (.*);
  mem_bus_model u_mem (.*);
  always #2 core_clk = ~core_clk;
  // Hang limit
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  assign sz = dma_wide ? 6'h04 : 6'h02;
  // FIFO model follows each item
  always @(posedge core_clk) if (dma_item_done === 1'b1) begin
    moved <= moved + sz;
    if (dma_write) rx_fifo_level <= rx_fifo_level - sz;
    else tx_fifo_level <= tx_fifo_level + sz;
    chk("width", dma_wide, cfg[WIDTH_BIT]);
  end
  task chk(input string s, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", s, exp, seen);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk("bresp", s_axi_bresp, RESP_OKAY);
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    {d, r} = {s_axi_rdata, s_axi_rresp};
  endtask : rd
  // Idle check short of threshold, then one transfer
  task xfer(input logic [15:0] c, input logic [5:0] prl, ptl, rl, tl, input int e);
    cfg = c;
    wr(ADDR_CONFIG, {16'h0, c});
    {rx_fifo_level, tx_fifo_level, slow, moved} <= {prl, ptl, w[6], 32'h0};
    repeat (8) @(posedge core_clk);
    chk("idle", bus_request, 0);
    rd(ADDR_STATUS);
    chk("status", d, {16'h0, 4'h0, ptl, prl});
    {rx_fifo_level, tx_fifo_level} <= {rl, tl};
    for (lim = 0; bus_request !== 1'b1 && lim < 9; lim++) @(posedge core_clk);
    chk("request", bus_request, 1);
    for (lim = 0; bus_request === 1'b1 && lim < 600; lim++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    chk("bytes", moved, e);
    {rx_fifo_level, tx_fifo_level} <= {6'h00, 6'h20};
  endtask : xfer
  task report_and_stop();
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(22055));
    repeat (12) @(posedge core_clk);
    rst_n <= 1;
    rd(ADDR_CONFIG);
    chk("cfg_reset", d, {16'h0, CONFIG_RESET});
    rd(4'h8);
    chk("bad_resp", r, RESP_SLVERR);
    chk("bad_data", d, 0);
    for (int k = 0; k < 4; k++) begin
      w = $urandom;
      xfer({8'h0, w[1:0], w[2], 1'b1, k[1:0], 2'h0}, rxb[k] - 2, 32, rxb[k], 32, rxb[k]);
      t = 36 - txb[k];
      xfer({8'h0, w[4:3], w[5], 1'b1, 2'h0, k[1:0]}, 0, txb[k], 0, txb[k] - 4,
           t < txb[k] ? t : txb[k]);
    end
    xfer({8'h0, w[1:0], w[2], 5'h00}, 2, 32, 20, 32, 20);
    xfer({8'h0, w[4:3], w[5], 5'h00}, 0, 8, 0, 4, 28);
    rd(ADDR_CONFIG);
    chk("cfg_back", d, {16'h0, cfg});
    report_and_stop();
  end
endmodule : tb_dma_fifo_burst_config
`default_nettype wire
